//--- fsac_pkg.sv
// package for the flash security access control block
// assumes a byte-wide register port and 512-byte flash pages
package fsac_pkg;
   // -----------------------------------------------------------------
   // register offsets and fields
   // -----------------------------------------------------------------
   localparam logic [7:0] STORE_CONTROL_REG_ADDR = 8'h8f;
   localparam logic [7:0] FLASH_KEY_REG_ADDR     = 8'hb7;
   localparam logic [7:0] RESET_SOURCE_REG_ADDR  = 8'h10;
   localparam logic [7:0] LOCK_STATE_REG_ADDR    = 8'h11;
   localparam int         WRITE_ENABLE_BIT       = 0;
   localparam int         ERASE_ENABLE_BIT       = 1;
   localparam int         FLASH_ERROR_BIT        = 6;
   localparam int         POWER_ON_RESET_BIT     = 1;
   localparam logic [7:0] KEY_FIRST              = 8'ha5;
   localparam logic [7:0] KEY_SECOND             = 8'hf1;
   localparam logic [7:0] RESET_VALUE            = 8'h00;
   // -----------------------------------------------------------------
   // flash geometry and timing
   // -----------------------------------------------------------------
   localparam int         ADDR_W                 = 14;
   localparam int         PAGE_SHIFT             = 9;
   localparam int         LOCK_BYTE_ADDR         = 16'h3dff;
   localparam int         RESERVED_BASE          = 16'h3e00;
   localparam int         CLK_MHZ                = 125;
   localparam int         WRITE_TIME_US          = 40;
   localparam int         WRITE_CYCLES           = WRITE_TIME_US * CLK_MHZ;
   // key sequence state, shown on the flash key register bits 1..0
   typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN, KEY_DEAD} fsac_key_t;
   // who issues a flash request
   typedef enum logic [1:0] {SRC_FW_UNLOCKED, SRC_FW_LOCKED, SRC_DEBUG} fsac_src_t;
   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_ERASE, OP_DEVICE_ERASE} fsac_op_t;
   // one flash request
   typedef struct packed {
      logic                valid;
      fsac_src_t           src;
      fsac_op_t            op;
      logic [ADDR_W-1:0]   addr;
      logic [7:0]          data;
   } fsac_req_t;
   // verdict for one request
   typedef struct packed {
      logic allow;
      logic ignore;
      logic error;
   } fsac_verdict_t;
endpackage

//--- fsac_checker.sv
// decision logic: judges one flash request against the lock state
// assumes the lock byte is latched at reset by the caller
`timescale 1ns/1ns
module fsac_checker #(
   parameter int ADDR_W = fsac_pkg::ADDR_W
) (
   input  wire fsac_pkg::fsac_req_t     req,
   input  wire logic [7:0]              lockByte,
   output fsac_pkg::fsac_verdict_t      verdict
);
   localparam int PAGE_LO = fsac_pkg::PAGE_SHIFT;
   logic [7:0]  lockedPages;
   logic        anyLocked;
   logic [ADDR_W-PAGE_LO-1:0] page;
   logic        inLockPage;
   logic        inReserved;
   logic        isLockByte;
   logic        inLockedPage;
   logic        fromDebug;
   logic        fwLocked;
   logic        forbid;

   // the address must reach past the reserved base
   if ((1 << ADDR_W) <= fsac_pkg::RESERVED_BASE)
   begin : g_bad_width
      $error("address too narrow for the reserved area");
   end

   // -----------------------------------------------------------------
   // page classification
   // -----------------------------------------------------------------
   assign lockedPages  = ~lockByte;
   assign anyLocked    = (lockByte != 8'hff);
   assign page         = req.addr[ADDR_W-1:PAGE_LO];
   assign inReserved   = (32'(req.addr) >= fsac_pkg::RESERVED_BASE);
   assign inLockPage   = (page == (ADDR_W-PAGE_LO)'(fsac_pkg::LOCK_BYTE_ADDR >> PAGE_LO));
   assign isLockByte   = (32'(req.addr) == fsac_pkg::LOCK_BYTE_ADDR);
   assign inLockedPage = (32'(page) < 32'(lockedPages));
   assign fromDebug    = (req.src == fsac_pkg::SRC_DEBUG);
   assign fwLocked     = (req.src == fsac_pkg::SRC_FW_LOCKED);

   // forbidden-access decision
   always_comb
   begin
      forbid = 1'b0;
      if (req.op == fsac_pkg::OP_DEVICE_ERASE)
         forbid = !fromDebug;
      else if (inReserved)
         forbid = 1'b1;
      else if (inLockPage && req.op == fsac_pkg::OP_ERASE)
         forbid = 1'b1;                      // debug gets device erase
      else if (isLockByte && req.op == fsac_pkg::OP_WRITE && lockByte != 8'hff)
         forbid = 1'b1;
      else if (inLockPage && anyLocked)
         forbid = !fwLocked;
      else if (inLockedPage && !inLockPage)
         forbid = !fwLocked;
      else
         forbid = 1'b0;
      if (inLockPage && req.op == fsac_pkg::OP_ERASE && !anyLocked && fromDebug)
         forbid = 1'b0;
   end

   // verdict: debug drops silently, firmware raises a reset
   always_comb
   begin
      verdict.allow  = req.valid && !forbid;
      verdict.ignore = req.valid && forbid && fromDebug;
      verdict.error  = req.valid && forbid && !fromDebug;
   end
endmodule

//--- fsac_top.sv
// flash security access control top: registers, key sequence, gating
// assumes one clock, requests held until busy falls, flash array outside
`timescale 1ns/1ns
// Behaviour
// - data-move writes go to flash if enabled; data-move reads go to data ram
// - software flash writes need the store write enable bit
// - software page erase needs write and erase enable bits
// - first n pages locked, n being the inverted lock byte
// - lock byte page locked whenever any lock byte bit is zero
// - unlocked pages open to debug and all firmware
// - locked pages: debug refused, unlocked firmware resets, locked firmware allowed
// - lock page while locked: debug refused, unlocked firmware resets
// - no lock: debug may erase lock page; firmware erase resets
// - while locked only debug device erase clears the lock page
// - lock byte changes while locked refused from debug, reset from firmware
// - written lock byte only altered by debug device erase
// - reserved area refused from debug, resets from firmware
// - prohibited firmware access resets and sets the flash error flag
// - prohibited debug operations silently dropped, no reset
// - new lock value applies only after the next device reset
// - interrupts during write or erase held until the operation ends
// - key 0xa5 then 0xf1 before each firmware write or erase; wrong key locks out
// - erase with both enables clears the whole page to all ones
// - execution stalled for the full write or erase time
module fsac_top #(
   parameter int WRITE_CYCLES = fsac_pkg::WRITE_CYCLES
) (
   input  wire  logic                        sys_clk,
   input  wire  logic                        arst_n,
   input  wire  logic [7:0]                  regAddr,
   input  wire  logic [7:0]                  regWdata,
   input  wire  logic                        regWrite,
   input  wire  logic                        regRead,
   output logic [7:0]                        regRdata,
   input  wire  fsac_pkg::fsac_req_t         req,
   input  wire  logic                        dataMoveRead,
   input  wire  logic [7:0]                  storedLockByte,
   input  wire  logic                        porEvent,
   output logic                              ramSelect,
   output logic                              flashRead,
   output logic                              flashWrite,
   output logic                              flashErase,
   output logic                              flashDeviceErase,
   output logic [fsac_pkg::ADDR_W-1:0]       flashAddr,
   output logic [7:0]                        flashData,
   output logic                              cpuStall,
   output logic                              holdInterrupts,
   output logic                              errorReset,
   output logic                              reqDone
);
   // refuse a zero write time at elaboration
   if (WRITE_CYCLES < 1)
   begin : g_bad_time
      $error("write time must be at least one cycle");
   end

   fsac_pkg::fsac_key_t     keyState_q;
   fsac_pkg::fsac_verdict_t verdict;
   fsac_pkg::fsac_req_t     gated;
   logic                    writeEn_q;
   logic                    eraseEn_q;
   logic                    flashErr_q;
   logic                    porFlag_q;
   logic [7:0]              lockLatched_q;
   logic                    lockCaught_q;
   logic [31:0]             busyCnt_q;
   logic                    busy;
   logic                    fwModify;
   logic                    keyOk;
   logic                    badKey;

   // -----------------------------------------------------------------
   // request shaping
   // -----------------------------------------------------------------
   assign busy     = (busyCnt_q != 32'h0);
   assign fwModify = req.valid && req.src != fsac_pkg::SRC_DEBUG
                     && req.op inside {fsac_pkg::OP_WRITE, fsac_pkg::OP_ERASE};
   assign keyOk    = (keyState_q == fsac_pkg::KEY_OPEN);

   // firmware write becomes erase when the erase enable is set
   always_comb
   begin
      gated = req;
      gated.valid = req.valid && !busy;
      if (req.src != fsac_pkg::SRC_DEBUG && req.op == fsac_pkg::OP_WRITE && eraseEn_q)
         gated.op = fsac_pkg::OP_ERASE;
   end

   // an enabled firmware modify without a good key locks the flash
   assign badKey = fwModify && !busy && writeEn_q && !keyOk;

   fsac_checker u_checker (
      .req      (gated),
      .lockByte (lockLatched_q),
      .verdict  (verdict)
   );

   // -----------------------------------------------------------------
   // lock byte capture, only on the first edge after reset release
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lockLatched_q <= 8'h00;
         lockCaught_q  <= 1'b0;
      end
      else if (!lockCaught_q)
      begin
         lockLatched_q <= storedLockByte;
         lockCaught_q  <= 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // control register: store write and erase enables
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         writeEn_q <= 1'b0;
         eraseEn_q <= 1'b0;
      end
      else if (regWrite && regAddr == fsac_pkg::STORE_CONTROL_REG_ADDR)
      begin
         writeEn_q <= regWdata[fsac_pkg::WRITE_ENABLE_BIT];
         eraseEn_q <= regWdata[fsac_pkg::ERASE_ENABLE_BIT];
      end
   end

   // key sequence; each enabled firmware write or erase request relocks it
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         keyState_q <= fsac_pkg::KEY_LOCKED;
      else if (keyState_q == fsac_pkg::KEY_DEAD)
         keyState_q <= fsac_pkg::KEY_DEAD;
      else if (badKey)
         keyState_q <= fsac_pkg::KEY_DEAD;
      else if (fwModify && !busy && writeEn_q && keyOk)
         keyState_q <= fsac_pkg::KEY_LOCKED;
      else if (regWrite && regAddr == fsac_pkg::FLASH_KEY_REG_ADDR)
      begin
         unique case (keyState_q)
            fsac_pkg::KEY_LOCKED:
               keyState_q <= (regWdata == fsac_pkg::KEY_FIRST) ?
                             fsac_pkg::KEY_HALF : fsac_pkg::KEY_DEAD;
            fsac_pkg::KEY_HALF:
               keyState_q <= (regWdata == fsac_pkg::KEY_SECOND) ?
                             fsac_pkg::KEY_OPEN : fsac_pkg::KEY_DEAD;
            fsac_pkg::KEY_OPEN:
               keyState_q <= fsac_pkg::KEY_DEAD;
            fsac_pkg::KEY_DEAD:
               keyState_q <= fsac_pkg::KEY_DEAD;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // reset source flags; error set wins over software clear
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         flashErr_q <= 1'b0;
         porFlag_q  <= 1'b1;
      end
      else
      begin
         if (verdict.error)
            flashErr_q <= 1'b1;
         else if (regWrite && regAddr == fsac_pkg::RESET_SOURCE_REG_ADDR)
            flashErr_q <= 1'b0;
         if (porEvent)
            porFlag_q <= 1'b1;
         else if (regWrite && regAddr == fsac_pkg::RESET_SOURCE_REG_ADDR)
            porFlag_q <= regWdata[fsac_pkg::POWER_ON_RESET_BIT];
      end
   end

   // -----------------------------------------------------------------
   // hardware-timed operation counter
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         busyCnt_q <= 32'h0;
      else if (busy)
         busyCnt_q <= busyCnt_q - 32'h1;
      else if (verdict.allow && gated.op != fsac_pkg::OP_READ
               && (gated.src == fsac_pkg::SRC_DEBUG || (writeEn_q && keyOk)))
         busyCnt_q <= 32'(WRITE_CYCLES);
   end

   // -----------------------------------------------------------------
   // flash strobes, all registered
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         flashRead        <= 1'b0;
         flashWrite       <= 1'b0;
         flashErase       <= 1'b0;
         flashDeviceErase <= 1'b0;
         flashAddr        <= '0;
         flashData        <= 8'h00;
         errorReset       <= 1'b0;
         reqDone          <= 1'b0;
         ramSelect        <= 1'b0;
      end
      else
      begin
         flashAddr  <= gated.addr;
         flashData  <= gated.data;
         ramSelect  <= dataMoveRead;
         flashRead  <= verdict.allow && gated.op == fsac_pkg::OP_READ;
         flashWrite <= verdict.allow && gated.op == fsac_pkg::OP_WRITE && !badKey
                       && (gated.src == fsac_pkg::SRC_DEBUG || writeEn_q);
         flashErase <= verdict.allow && gated.op == fsac_pkg::OP_ERASE && !badKey
                       && (gated.src == fsac_pkg::SRC_DEBUG
                           || (writeEn_q && eraseEn_q));
         flashDeviceErase <= verdict.allow && gated.op == fsac_pkg::OP_DEVICE_ERASE;
         errorReset <= verdict.error;
         reqDone    <= gated.valid;
      end
   end

   // stall and interrupt hold follow the operation timer
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cpuStall       <= 1'b0;
         holdInterrupts <= 1'b0;
      end
      else
      begin
         cpuStall       <= busy;
         holdInterrupts <= busy;
      end
   end

   // -----------------------------------------------------------------
   // register read port, data one cycle after the strobe
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         regRdata <= fsac_pkg::RESET_VALUE;
      else if (regRead)
      begin
         regRdata <= 8'h00;
         unique case (regAddr)
            fsac_pkg::STORE_CONTROL_REG_ADDR: regRdata <= {6'h00, eraseEn_q, writeEn_q};
            fsac_pkg::FLASH_KEY_REG_ADDR:     regRdata <= {6'h00, keyState_q};
            fsac_pkg::RESET_SOURCE_REG_ADDR:
               regRdata <= {1'b0, flashErr_q, 4'h0, porFlag_q, 1'b0};
            fsac_pkg::LOCK_STATE_REG_ADDR:    regRdata <= lockLatched_q;
            default:                          regRdata <= 8'h00;
         endcase
      end
      else
         regRdata <= 8'h00;
   end
endmodule

//--- fsac_top_chk.sv
// checker for the flash access control top: gating and timing relations
// assumes it is bound to fsac_top and sees only that module's ports
`timescale 1ns/1ns
module fsac_top_chk #(
   parameter int WRITE_CYCLES = fsac_pkg::WRITE_CYCLES
) (
   input wire logic                sys_clk,
   input wire logic                arst_n,
   input wire fsac_pkg::fsac_req_t req,
   input wire logic                dataMoveRead,
   input wire logic                ramSelect,
   input wire logic                flashRead,
   input wire logic                flashWrite,
   input wire logic                flashErase,
   input wire logic                flashDeviceErase,
   input wire logic [13:0]         flashAddr,
   input wire logic                cpuStall,
   input wire logic                holdInterrupts,
   input wire logic                errorReset,
   input wire logic                reqDone
);
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   logic [15:0] stallCnt_q;
   logic        anyStrobe;
   logic        onLockPage;
   // strobe summary and lock page decode
   assign anyStrobe = flashRead | flashWrite | flashErase;
   assign onLockPage = (int'(flashAddr) >> 9) == (fsac_pkg::LOCK_BYTE_ADDR >> 9);
   // length of the current stall run
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         stallCnt_q <= 16'h0000;
      else if (cpuStall)
         stallCnt_q <= stallCnt_q + 16'h0001;
      else
         stallCnt_q <= 16'h0000;
   end
   a_ram_select: assert property (ramSelect == $past(dataMoveRead))
      else $error("data-move read did not select data ram");
   a_error_clean: assert property (errorReset |-> !(flashWrite || flashErase || flashDeviceErase))
      else $error("flash modified on an error reset");
   a_debug_quiet: assert property (errorReset |-> $past(req.valid) && $past(req.src) != fsac_pkg::SRC_DEBUG)
      else $error("error reset without a firmware request");
   a_stall_start: assert property ((flashWrite || flashErase) |-> ##[0:1] cpuStall)
      else $error("no stall after a write or erase");
   a_stall_len: assert property (stallCnt_q <= WRITE_CYCLES + 1)
      else $error("stall lasts too long");
   a_stall_exact: assert property ($fell(cpuStall) |-> stallCnt_q == WRITE_CYCLES)
      else $error("stall differs from the write time");
   a_irq_held: assert property (cpuStall |-> holdInterrupts)
      else $error("interrupts not held during an operation");
   a_no_reserved: assert property (anyStrobe |-> int'(flashAddr) < fsac_pkg::RESERVED_BASE)
      else $error("reserved area reached");
   a_dev_erase_src: assert property (flashDeviceErase |-> $past(req.src) == fsac_pkg::SRC_DEBUG && $past(req.op) == fsac_pkg::OP_DEVICE_ERASE)
      else $error("device erase not from debug");
   a_lock_erase_src: assert property (flashErase && onLockPage |-> $past(req.src) == fsac_pkg::SRC_DEBUG)
      else $error("lock page erased by firmware");
   a_strobe_done: assert property (anyStrobe |-> reqDone)
      else $error("strobe without done");
endmodule

bind fsac_top fsac_top_chk #(.WRITE_CYCLES(WRITE_CYCLES)) i_fsac_top_chk (
   .sys_clk(sys_clk), .arst_n(arst_n), .req(req), .dataMoveRead(dataMoveRead),
   .ramSelect(ramSelect), .flashRead(flashRead), .flashWrite(flashWrite),
   .flashErase(flashErase), .flashDeviceErase(flashDeviceErase), .flashAddr(flashAddr),
   .cpuStall(cpuStall), .holdInterrupts(holdInterrupts), .errorReset(errorReset),
   .reqDone(reqDone)
);

//--- fsac_flash_model.sv
// flash array stand-in: holds the lock byte and answers the strobes
// assumes one-cycle strobes from fsac_top and preload only before a reset
`timescale 1ns/1ns
module fsac_flash_model (
   input  wire logic        sys_clk,
   input  wire logic        flashWrite,
   input  wire logic        flashErase,
   input  wire logic        flashDeviceErase,
   input  wire logic [13:0] flashAddr,
   input  wire logic [7:0]  flashData,
   output logic [7:0]       storedLockByte
);
   logic [7:0] lock_q = 8'hff;
   logic       lockPage;
   // lock byte out and lock page decode
   assign storedLockByte = lock_q;
   assign lockPage = (int'(flashAddr) >> 9) == (fsac_pkg::LOCK_BYTE_ADDR >> 9);
   // preload so the top latches it at the next reset
   task automatic load(input logic [7:0] v);
      lock_q = v;
   endtask
   // programming clears bits only, erases set them back to ones
   always @(posedge sys_clk)
   begin
      if (flashDeviceErase)
         lock_q <= 8'hff;
      else if (flashErase && lockPage)
         lock_q <= 8'hff;
      else if (flashWrite && int'(flashAddr) == fsac_pkg::LOCK_BYTE_ADDR)
         lock_q <= lock_q & flashData;
   end
endmodule

//--- tb.sv
// testbench for the flash access control top
// assumes the flash model feeds the lock byte; short write time in sim
`timescale 1ns/1ns
module tb;
   localparam logic [1:0] FU = 2'h0, FL = 2'h1, DB = 2'h2;
   localparam logic [1:0] RD = 2'h0, WR = 2'h1, ER = 2'h2, DE = 2'h3;
   localparam logic [7:0] CTL = fsac_pkg::STORE_CONTROL_REG_ADDR;
   localparam logic [7:0] KEY = fsac_pkg::FLASH_KEY_REG_ADDR;
   localparam logic [7:0] SRC = fsac_pkg::RESET_SOURCE_REG_ADDR;
   localparam logic [7:0] LST = fsac_pkg::LOCK_STATE_REG_ADDR;
   logic                sys_clk = 1'b0;
   logic                arst_n = 1'b0;
   logic [7:0]          regAddr = 8'h00;
   logic [7:0]          regWdata = 8'h00;
   logic                regWrite = 1'b0;
   logic                regRead = 1'b0;
   fsac_pkg::fsac_req_t req = '0;
   logic                dataMoveRead = 1'b0;
   logic                porEvent = 1'b0;
   logic [7:0]          regRdata, storedLockByte, flashData, lastData;
   logic [13:0]         flashAddr, lastAddr;
   logic                ramSelect, flashRead, flashWrite, flashErase, flashDeviceErase;
   logic                cpuStall, holdInterrupts, errorReset, reqDone;
   int                  miscompares = 0;
   int                  totalChecks = 0;
   // design and flash stand-in
   fsac_top #(.WRITE_CYCLES(4)) i_fsac_top (.sys_clk(sys_clk), .arst_n(arst_n),
      .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .regRdata(regRdata), .req(req), .dataMoveRead(dataMoveRead),
      .storedLockByte(storedLockByte), .porEvent(porEvent), .ramSelect(ramSelect),
      .flashRead(flashRead), .flashWrite(flashWrite), .flashErase(flashErase),
      .flashDeviceErase(flashDeviceErase), .flashAddr(flashAddr), .flashData(flashData),
      .cpuStall(cpuStall), .holdInterrupts(holdInterrupts), .errorReset(errorReset),
      .reqDone(reqDone));
   fsac_flash_model i_fsac_flash_model (.sys_clk(sys_clk), .flashWrite(flashWrite),
      .flashErase(flashErase), .flashDeviceErase(flashDeviceErase),
      .flashAddr(flashAddr), .flashData(flashData), .storedLockByte(storedLockByte));
   // 125 MHz clock
   always #4 sys_clk = ~sys_clk;
   task automatic chk(input string n, input logic [15:0] s, e);
      totalChecks++;
      if (s !== e)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic end_sim;
      if (miscompares == 0 && totalChecks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge sys_clk);
      regWrite <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, m, e, input string n);
      @(posedge sys_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      #1;
      chk(n, {8'h00, regRdata & m}, {8'h00, e});
   endtask
   task automatic key;
      wr(KEY, fsac_pkg::KEY_FIRST);
      wr(KEY, fsac_pkg::KEY_SECOND);
   endtask
   task automatic rst;
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask
   // one request; e is {read, write, erase, device erase, error, done}
   task automatic go(input logic [1:0] s, o, input logic [13:0] a, input logic [7:0] d,
                     input logic [5:0] e);
      @(posedge sys_clk);
      req <= '{1'b1, fsac_pkg::fsac_src_t'(s), fsac_pkg::fsac_op_t'(o), a, d};
      @(posedge sys_clk);
      req.valid <= 1'b0;
      #1;
      lastAddr = flashAddr;
      lastData = flashData;
      chk("strobes", {10'h000, flashRead, flashWrite, flashErase, flashDeviceErase,
          errorReset, reqDone}, {10'h000, e});
      @(posedge sys_clk);
      #1;
      chk("stall", {14'h0000, cpuStall, holdInterrupts}, {14'h0000, {2{|e[4:2]}}});
      @(posedge sys_clk);
      for (int i = 0; i < 40 && cpuStall !== 1'b0; i++) @(posedge sys_clk);
   endtask
   task automatic t_regs;
      rc(CTL, 8'hff, 8'h00, "ctl");
      rc(8'h55, 8'hff, 8'h00, "unmapped");
      wr(CTL, 8'hff);
      rc(CTL, 8'hff, 8'h03, "ctlBits");
      wr(CTL, 8'h00);
      wr(SRC, 8'h00);
      rc(SRC, 8'h42, 8'h00, "srcClear");
      @(posedge sys_clk);
      dataMoveRead <= 1'b1;
      porEvent <= 1'b1;
      @(posedge sys_clk);
      dataMoveRead <= 1'b0;
      porEvent <= 1'b0;
      #1;
      chk("ramSelect", {15'h0000, ramSelect}, 16'h0001);
      rc(SRC, 8'h02, 8'h02, "porFlag");
   endtask
   task automatic t_write;
      go(FU, WR, 14'h0400, 8'h5a, 6'h01);
      wr(CTL, 8'h01);
      key();
      rc(KEY, 8'h03, 8'h02, "keyOpen");
      go(FU, WR, 14'h0400, 8'h5a, 6'h11);
      chk("addr", {2'h0, lastAddr}, 16'h0400);
      chk("data", {8'h00, lastData}, 16'h005a);
      rc(KEY, 8'h03, 8'h00, "keyRelock");
      go(FU, WR, 14'h0401, 8'h00, 6'h01);
      rc(KEY, 8'h03, 8'h03, "keyDead");
   endtask
   task automatic t_erase;
      rst();
      wr(KEY, 8'h11);
      rc(KEY, 8'h03, 8'h03, "badKey");
      rst();
      wr(CTL, 8'h03);
      key();
      go(FU, WR, 14'h0655, 8'h00, 6'h09);
      chk("page", {11'h000, lastAddr[13:9]}, 16'h0003);
      go(DB, ER, 14'h3dff, 8'h00, 6'h09);
      key();
      go(FL, WR, 14'h3dff, 8'h00, 6'h03);
      rc(SRC, 8'h40, 8'h40, "errFlag");
   endtask
   task automatic t_locked;
      i_fsac_flash_model.load(8'hfd);
      rst();
      rc(LST, 8'hff, 8'hfd, "lockState");
      go(DB, RD, 14'h0000, 8'h00, 6'h01);
      go(FL, RD, 14'h0200, 8'h00, 6'h21);
      go(DB, RD, 14'h0400, 8'h00, 6'h21);
      go(DB, RD, 14'h3dff, 8'h00, 6'h01);
      go(FL, RD, 14'h3c00, 8'h00, 6'h21);
      go(FU, RD, 14'h3c00, 8'h00, 6'h03);
      go(DB, RD, 14'h3e00, 8'h00, 6'h01);
      go(DB, WR, 14'h3dff, 8'h00, 6'h01);
      go(FU, RD, 14'h01ff, 8'h00, 6'h03);
      go(FL, RD, 14'h3e10, 8'h00, 6'h03);
      go(DB, ER, 14'h3dff, 8'h00, 6'h01);
      go(DB, DE, 14'h0000, 8'h00, 6'h05);
   endtask
   task automatic t_relock;
      rst();
      wr(CTL, 8'h01);
      key();
      go(FU, WR, 14'h3dff, 8'hfe, 6'h11);
      rc(LST, 8'hff, 8'hff, "lockHeld");
      go(DB, RD, 14'h0000, 8'h00, 6'h21);
      rst();
      rc(LST, 8'hff, 8'hfe, "lockNew");
      go(DB, RD, 14'h0000, 8'h00, 6'h01);
      wr(CTL, 8'h01);
      key();
      go(FL, WR, 14'h3dff, 8'h00, 6'h03);
   endtask
   // main sequence
   initial
   begin
      repeat (12) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      t_regs();
      t_write();
      t_erase();
      t_locked();
      t_relock();
      end_sim();
   end
   // watchdog well beyond the expected run
   initial
   begin
      #300000;
      miscompares++;
      end_sim();
   end
endmodule
